// >>> hw/scnt_pkg.sv
// Constants, register map and types of the sense counter register block.
// Assumes a 32-bit APB master; register indices are word indices (byte address = 4 x index).
package scnt_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_COUNT_LOW = 10'h0a4;
    localparam logic [9:0] IDX_COUNT_HIGH = 10'h0a5;
    localparam logic [9:0] IDX_EVENT_STATUS = 10'h0a6;
    localparam logic [9:0] IDX_TIMER = 10'h0a7;
    localparam logic [9:0] IDX_CONTROL = 10'h0b0;

    localparam int IDX_W = 10;
    localparam int BYTE_LSB = 2;

    // Status and mask register fields.
    localparam int BIT_INPUT_EVENT_FLAG = 7;
    localparam int BIT_LOW_CARRY_FLAG = 6;
    localparam int BIT_HIGH_CARRY_FLAG = 5;
    localparam int BIT_MEASURE_DONE_FLAG = 4;
    localparam int FLAG_LSB = 4;
    localparam int MASK_LSB = 0;
    localparam int EVT_N = 4;

    // Control register fields.
    localparam int SRC_SEL_LSB = 0;
    localparam int SRC_SEL_W = 3;
    localparam int BIT_INPUT_INVERT = 3;
    localparam int BIT_RELAX_OSC_CLOCK_SELECT = 4;
    localparam int BIT_PULSE_WIDTH_MODE = 5;
    localparam int BIT_BLOCK_ENABLE = 7;

    localparam int TIMER_W = 7;
    localparam int REG_W = 8;
    localparam int SRC_N = 7;

    localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
    localparam logic [6:0] RST_TIMER = 7'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MEAS_IDLE,
        MEAS_ARMED,
        MEAS_RUN,
        MEAS_DONE
    } scnt_meas_state_t;

endpackage : scnt_pkg

// >>> hw/scnt_ctr_if.sv
// Carrier between the register block and its counter core.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface scnt_ctr_if #(
    parameter int CNT_W = 8
);
    logic enable;
    logic run;
    logic high_tick;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic low_carry;
    logic high_carry;

    modport core (
        input enable,
        input run,
        input high_tick,
        output low_cnt,
        output high_cnt,
        output low_carry,
        output high_carry
    );

    modport ctl (
        output enable,
        output run,
        output high_tick,
        input low_cnt,
        input high_cnt,
        input low_carry,
        input high_carry
    );
endinterface : scnt_ctr_if

// >>> hw/scnt_counter.sv
// Low and high byte measurement counters with carry pulses.
// Assumes high_tick is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/1ps
module scnt_counter #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control side
    scnt_ctr_if.core ctr
);

    localparam logic [CNT_W-1:0] CNT_MAX = '1;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic high_step;

    assign high_step = ctr.run & ctr.high_tick;

    // Carries are pulses in the cycle the byte wraps.
    assign ctr.low_carry = ctr.run & (ctr.low_cnt == CNT_MAX);
    assign ctr.high_carry = high_step & (ctr.high_cnt == CNT_MAX);

    // Low byte counts system clock cycles while the measurement runs.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctr.low_cnt <= '0;
        end else if (!ctr.enable) begin
            ctr.low_cnt <= '0;
        end else if (ctr.run) begin
            ctr.low_cnt <= ctr.low_cnt + CNT_ONE;
        end
    end

    // High byte counts its own time base so both bytes give two resolutions.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctr.high_cnt <= '0;
        end else if (!ctr.enable) begin
            ctr.high_cnt <= '0;
        end else if (high_step) begin
            ctr.high_cnt <= ctr.high_cnt + CNT_ONE;
        end
    end

endmodule : scnt_counter

// >>> hw/scnt_top.sv
// APB register block of the sense measurement counter, with the measurement sequencer.
// Assumes all inputs are synchronous to sys_clk and ticks are one-cycle pulses.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module scnt_top #(
    parameter int CNT_W = 8,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Measurement inputs
    input wire logic [scnt_pkg::SRC_N-1:0] meas_src,
    input wire logic sys_freq_tick,
    input wire logic relax_osc_tick,

    // Status
    output logic block_irq,
    output logic counter_running
);

    // Refuse parameter values that the decode and the register views cannot serve.
    if (CNT_W < 1 || CNT_W > scnt_pkg::REG_W) begin : g_bad_cnt_w
        $error("CNT_W must lie between 1 and the register width.");
    end
    if (ADDR_W < scnt_pkg::IDX_W + scnt_pkg::BYTE_LSB || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W does not fit the register map.");
    end
    if (scnt_pkg::SRC_N >= (1 << scnt_pkg::SRC_SEL_W)) begin : g_bad_src_n
        $error("SRC_N leaves no select code for the constant low input.");
    end
    if (scnt_pkg::TIMER_W > scnt_pkg::REG_W) begin : g_bad_timer_w
        $error("TIMER_W is wider than a register.");
    end

    localparam int PAD_W = 32 - scnt_pkg::REG_W;
    localparam int CPAD_W = scnt_pkg::REG_W - CNT_W;

    // Bus decode.
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic wr_stat;
    logic wr_timer;
    logic wr_ctrl;
    logic [scnt_pkg::IDX_W-1:0] idx;
    logic aligned;
    logic hit_low;
    logic hit_high;
    logic hit_stat;
    logic hit_timer;
    logic hit_ctrl;
    logic mapped;

    // Registers.
    logic [scnt_pkg::EVT_N-1:0] flag_r;
    logic [scnt_pkg::EVT_N-1:0] flag_nxt;
    logic [scnt_pkg::EVT_N-1:0] mask_r;
    logic [scnt_pkg::TIMER_W-1:0] timer_r;
    logic [scnt_pkg::REG_W-1:0] ctrl_r;
    logic [31:0] prdata_nxt;

    // Control fields.
    logic block_enable;
    logic [scnt_pkg::SRC_SEL_W-1:0] input_source_select;
    logic input_invert;
    logic relax_osc_clock_select;
    logic pulse_width_mode;

    // Input path and sequencer.
    logic src_raw;
    logic sel_in;
    logic sel_prev_r;
    logic sel_rise;
    logic sel_fall;
    logic stop_event;
    logic measure_done;
    scnt_pkg::scnt_meas_state_t state_r;
    scnt_pkg::scnt_meas_state_t state_nxt;

    // Event vector in flag order: input, low carry, high carry, done.
    logic [scnt_pkg::EVT_N-1:0] evt;
    logic [scnt_pkg::EVT_N-1:0] wr_flag_clr;
    logic [scnt_pkg::EVT_N-1:0] irq_src;
    logic [scnt_pkg::REG_W-1:0] stat_view;
    logic [scnt_pkg::REG_W-1:0] low_view;
    logic [scnt_pkg::REG_W-1:0] high_view;

    scnt_ctr_if #(.CNT_W(CNT_W)) ctr_bus ();

    scnt_counter #(.CNT_W(CNT_W)) i_scnt_counter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ctr(ctr_bus.core)
    );

    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign idx = paddr[scnt_pkg::BYTE_LSB +: scnt_pkg::IDX_W];
    // Address bits above the index must be zero, so the map has no aliases.
    assign aligned = (paddr[scnt_pkg::BYTE_LSB-1:0] == '0)
                     && (paddr[ADDR_W-1:scnt_pkg::BYTE_LSB] == (ADDR_W-scnt_pkg::BYTE_LSB)'(idx));
    assign hit_low = aligned && (idx == scnt_pkg::IDX_COUNT_LOW);
    assign hit_high = aligned && (idx == scnt_pkg::IDX_COUNT_HIGH);
    assign hit_stat = aligned && (idx == scnt_pkg::IDX_EVENT_STATUS);
    assign hit_timer = aligned && (idx == scnt_pkg::IDX_TIMER);
    assign hit_ctrl = aligned && (idx == scnt_pkg::IDX_CONTROL);
    assign mapped = hit_low | hit_high | hit_stat | hit_timer | hit_ctrl;

    // Zero wait states: read data is captured in the setup cycle.
    assign pready = access_ph;
    assign pslverr = access_ph & ~mapped;
    assign wr_en = access_ph & pwrite & mapped;
    // One strobe per writable register keeps each update block to its own concern.
    assign wr_stat = wr_en & hit_stat;
    assign wr_timer = wr_en & hit_timer;
    assign wr_ctrl = wr_en & hit_ctrl;

    assign block_enable = ctrl_r[scnt_pkg::BIT_BLOCK_ENABLE];
    assign input_source_select = ctrl_r[scnt_pkg::SRC_SEL_LSB +: scnt_pkg::SRC_SEL_W];
    assign input_invert = ctrl_r[scnt_pkg::BIT_INPUT_INVERT];
    assign relax_osc_clock_select = ctrl_r[scnt_pkg::BIT_RELAX_OSC_CLOCK_SELECT];
    assign pulse_width_mode = ctrl_r[scnt_pkg::BIT_PULSE_WIDTH_MODE];

    // The last select code picks a constant low input.
    always_comb begin
        src_raw = 1'b0;
        if (int'(input_source_select) < scnt_pkg::SRC_N) begin
            src_raw = meas_src[input_source_select];
        end
    end

    // A change of select code or invert bit can look like an edge and set the input flag;
    // software should clear the flags after reconfiguring the input path.
    assign sel_in = src_raw ^ input_invert;
    assign sel_rise = sel_in & ~sel_prev_r;
    assign sel_fall = ~sel_in & sel_prev_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_r <= 1'b0;
        end else begin
            sel_prev_r <= sel_in;
        end
    end

    // Period mode stops on the next rising edge, pulse width mode on the falling edge.
    assign stop_event = pulse_width_mode ? sel_fall : sel_rise;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            scnt_pkg::MEAS_IDLE: begin
                if (block_enable) begin
                    state_nxt = scnt_pkg::MEAS_ARMED;
                end
            end
            scnt_pkg::MEAS_ARMED: begin
                if (sel_rise) begin
                    state_nxt = scnt_pkg::MEAS_RUN;
                end
            end
            scnt_pkg::MEAS_RUN: begin
                if (stop_event) begin
                    state_nxt = scnt_pkg::MEAS_DONE;
                end
            end
            // Counts stay frozen here until software clears the enable bit to re-arm.
            scnt_pkg::MEAS_DONE: begin
                state_nxt = scnt_pkg::MEAS_DONE;
            end
            default: begin
                state_nxt = scnt_pkg::MEAS_IDLE;
            end
        endcase
        if (!block_enable) begin
            state_nxt = scnt_pkg::MEAS_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= scnt_pkg::MEAS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign measure_done = (state_r == scnt_pkg::MEAS_RUN) && stop_event && block_enable;
    assign counter_running = (state_r == scnt_pkg::MEAS_RUN);

    assign ctr_bus.enable = block_enable;
    // Only the run state advances the counters, so a finished measurement holds its counts.
    assign ctr_bus.run = counter_running;
    // The high byte runs on relaxation ticks or on the system frequency tick.
    assign ctr_bus.high_tick = relax_osc_clock_select ? relax_osc_tick
                                                      : sys_freq_tick;

    assign evt = {sel_rise, ctr_bus.low_carry, ctr_bus.high_carry, measure_done};

    // A zero written to a flag clears it; a one leaves it alone.
    assign wr_flag_clr = wr_stat
                         ? ~pwdata[scnt_pkg::FLAG_LSB +: scnt_pkg::EVT_N]
                         : '0;

    // Setting beats clearing so an event in the clearing cycle is kept.
    assign flag_nxt = (flag_r & ~wr_flag_clr) | evt;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= scnt_pkg::RST_EVENT_STATUS[scnt_pkg::FLAG_LSB +: scnt_pkg::EVT_N];
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Masks are plain storage; keeping them still while enabled is up to software.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= scnt_pkg::RST_EVENT_STATUS[scnt_pkg::MASK_LSB +: scnt_pkg::EVT_N];
        end else if (wr_stat) begin
            mask_r <= pwdata[scnt_pkg::MASK_LSB +: scnt_pkg::EVT_N];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_r <= scnt_pkg::RST_TIMER;
        end else if (wr_timer) begin
            timer_r <= pwdata[scnt_pkg::TIMER_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= scnt_pkg::RST_CONTROL;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata[scnt_pkg::REG_W-1:0];
        end
    end

    // Mask positions line up with flag positions, shifted by four.
    for (genvar e = 0; e < scnt_pkg::EVT_N; e++) begin : g_irq_src
        assign irq_src[e] = flag_r[e] & mask_r[e];
    end
    assign block_irq = |irq_src;

    assign stat_view = {flag_r, mask_r};
    assign low_view = {{CPAD_W{1'b0}}, ctr_bus.low_cnt};
    assign high_view = {{CPAD_W{1'b0}}, ctr_bus.high_cnt};

    // Count bytes are read live; a read mid-measurement is not guaranteed coherent.
    always_comb begin
        prdata_nxt = scnt_pkg::RDATA_ZERO;
        if (aligned) begin
            case (idx)
                scnt_pkg::IDX_COUNT_LOW: begin
                    prdata_nxt = {{PAD_W{1'b0}}, low_view};
                end
                scnt_pkg::IDX_COUNT_HIGH: begin
                    prdata_nxt = {{PAD_W{1'b0}}, high_view};
                end
                scnt_pkg::IDX_EVENT_STATUS: begin
                    prdata_nxt = {{PAD_W{1'b0}}, stat_view};
                end
                scnt_pkg::IDX_TIMER: begin
                    prdata_nxt = {{(32 - scnt_pkg::TIMER_W){1'b0}}, timer_r};
                end
                scnt_pkg::IDX_CONTROL: begin
                    prdata_nxt = {{PAD_W{1'b0}}, ctrl_r};
                end
                default: begin
                    prdata_nxt = scnt_pkg::RDATA_ZERO;
                end
            endcase
        end
    end

    // Read data is loaded at the end of the setup cycle and stands through the access
    // phase, which is what lets the slave answer without wait states.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= scnt_pkg::RDATA_ZERO;
        end else if (setup_ph && !pwrite) begin
            prdata <= prdata_nxt;
        end
    end

endmodule : scnt_top

// >>> verification/scnt_assertions.sv
// Port-level checks of the sense counter register block.
// Assumes it is bound to scnt_top and sees only that module's ports.
`timescale 1ns/1ps
module scnt_top_assertions #(
    parameter int CNT_W = 8,
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Measurement and status
    input wire logic [scnt_pkg::SRC_N-1:0] meas_src,
    input wire logic sys_freq_tick,
    input wire logic relax_osc_tick,
    input wire logic block_irq,
    input wire logic counter_running
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    wire logic [ADDR_W-3:0] widx = paddr[ADDR_W-1:2];
    wire logic map_ok = (paddr[1:0] == 2'h0) && (widx == scnt_pkg::IDX_COUNT_LOW ||
        widx == scnt_pkg::IDX_COUNT_HIGH || widx == scnt_pkg::IDX_EVENT_STATUS ||
        widx == scnt_pkg::IDX_TIMER || widx == scnt_pkg::IDX_CONTROL);

    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_rd;
        s_acc ##0 !pwrite;
    endsequence
    sequence s_wr(logic [ADDR_W-3:0] ix);
        s_acc ##0 pwrite && map_ok && widx == ix;
    endsequence

    AST_ZERO_WAIT: assert property (s_acc |-> pready)
        else $error("pready low in an access phase");
    AST_ERR_MAP: assert property (s_acc |-> pslverr == !map_ok)
        else $error("pslverr does not match the address map");
    AST_UNMAPPED_ZERO: assert property (s_rd ##0 !map_ok |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    AST_UPPER_ZERO: assert property (s_rd |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    AST_TIMER_MSB: assert property (s_rd ##0 widx == scnt_pkg::IDX_TIMER |-> !prdata[7])
        else $error("timer bit 7 reads one");
    // No new write can land in the next two cycles, since a setup cycle must come first.
    AST_MASK_OFF_QUIET: assert property (
        s_wr(scnt_pkg::IDX_EVENT_STATUS) ##0 pwdata[3:0] == 4'h0 |=> !block_irq [*2])
        else $error("interrupt high with all masks off");
    AST_IRQ_FALL_WRITE: assert property (
        $fell(block_irq) |-> $past(psel) && $past(penable) && $past(pwrite))
        else $error("interrupt fell without a write");
    // Two cycles: the control write lands first, then the sequencer leaves its run state.
    AST_DISABLE_STOPS: assert property (
        s_wr(scnt_pkg::IDX_CONTROL) ##0 !pwdata[7] |-> ##2 !counter_running)
        else $error("counter still running after disable");
endmodule : scnt_top_assertions

bind scnt_top scnt_top_assertions #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) i_scnt_top_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_src(meas_src), .sys_freq_tick(sys_freq_tick), .relax_osc_tick(relax_osc_tick),
    .block_irq(block_irq), .counter_running(counter_running));

// >>> verification/scnt_tb_top.sv
// Self-checking bench of the sense counter register block.
// Assumes zero-wait APB answers and ticks given as one-cycle pulses.
`timescale 1ns/1ps
module scnt_tb_top;
    localparam logic [9:0] LO = scnt_pkg::IDX_COUNT_LOW;
    localparam logic [9:0] HI = scnt_pkg::IDX_COUNT_HIGH;
    localparam logic [9:0] ST = scnt_pkg::IDX_EVENT_STATUS;
    localparam logic [9:0] TM = scnt_pkg::IDX_TIMER;
    localparam logic [9:0] CT = scnt_pkg::IDX_CONTROL;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, block_irq, counter_running;
    logic [6:0] meas_src = 7'h00;
    logic sys_freq_tick = 1'b0, relax_osc_tick = 1'b0;
    int num_errors = 0, n_tests = 0, cyc = 0;

    always #25 sys_clk = ~sys_clk;

    scnt_top i_scnt_top (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_src(meas_src), .sys_freq_tick(sys_freq_tick),
        .relax_osc_tick(relax_osc_tick), .block_irq(block_irq),
        .counter_running(counter_running));

    task automatic conclude;
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'h0};
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, ix, d, rd, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rdc(input logic [9:0] ix, input logic [7:0] exp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, ix, 8'h00, rd, e);
        chk(rd, {24'h00_0000, exp});
        chk({31'h0, e}, 32'h0);
    endtask : rdc

    task automatic t_regs;
        logic [31:0] rd;
        logic e;
        rdc(LO, 8'h00);
        rdc(ST, 8'h00);
        rdc(TM, 8'h00);
        wr(LO, 8'hff);
        wr(HI, 8'h5a);
        rdc(LO, 8'h00);
        rdc(HI, 8'h00);
        wr(TM, 8'hff);
        rdc(TM, 8'h7f);
        apb(1'b0, 10'h0a8, 8'h00, rd, e);
        chk({31'h0, e}, 32'h1);
        chk(rd, 32'h0000_0000);
    endtask : t_regs

    // Ticks come every other cycle, well clear of the start and stop edges; the low byte
    // counts every clock from the one after the start edge through the stop edge.
    task automatic t_meas(input logic [7:0] ctl, input int ns, input int nr,
                          input logic [7:0] lexp, input logic [7:0] hexp, input logic [7:0] sexp);
        int n = ns > nr ? ns : nr;
        meas_src[0] <= 1'b0;
        wr(CT, ctl);
        wr(ST, 8'h00);
        repeat (2) @(posedge sys_clk);
        meas_src[0] <= 1'b1;
        for (int i = 0; i < 2 * n + 4; i++) begin
            @(posedge sys_clk);
            sys_freq_tick <= i > 1 && i % 2 == 0 && i / 2 <= ns;
            relax_osc_tick <= i > 1 && i % 2 == 0 && i / 2 <= nr;
        end
        meas_src[0] <= 1'b0;
        if (!ctl[5]) begin
            repeat (3) @(posedge sys_clk);
            meas_src[0] <= 1'b1;
        end
        repeat (4) @(posedge sys_clk);
        chk({31'h0, counter_running}, 32'h0);
        rdc(LO, lexp);
        rdc(HI, hexp);
        rdc(ST, sexp);
    endtask : t_meas

    task automatic t_off;
        wr(CT, 8'h00);
        rdc(LO, 8'h00);
        rdc(HI, 8'h00);
    endtask : t_off

    task automatic t_mask;
        for (int i = 0; i < 4; i++) begin
            wr(ST, 8'hf0 | (8'h01 << i));
            @(negedge sys_clk);
            chk({31'h0, block_irq}, 32'h1);
        end
        wr(ST, 8'hf0);
        @(negedge sys_clk);
        chk({31'h0, block_irq}, 32'h0);
        // Clear one flag and unmask only that source: a crossed mask lane would raise the irq.
        for (int i = 0; i < 4; i++) begin
            wr(ST, ((8'h70 >> i) & 8'hf0) | (8'h08 >> i));
            @(negedge sys_clk);
            chk({31'h0, block_irq}, 32'h0);
            rdc(ST, ((8'h70 >> i) & 8'hf0) | (8'h08 >> i));
        end
    endtask : t_mask

    task automatic t_inv;
        wr(CT, 8'h08);
        meas_src[0] <= 1'b1;
        wr(ST, 8'h00);
        rdc(ST, 8'h00);
        meas_src[0] <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rdc(ST, 8'h80);
    endtask : t_inv

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs;
        t_meas(8'h80, 3, 5, 8'h11, 8'h03, 8'h90);
        t_off;
        t_meas(8'ha0, 4, 0, 8'h0c, 8'h04, 8'h90);
        t_off;
        t_meas(8'h90, 1, 258, 8'h0b, 8'h02, 8'hf0);
        t_off;
        // Masks change only while the block is disabled.
        t_mask;
        t_inv;
        conclude;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            conclude;
        end
    end
endmodule : scnt_tb_top
